// *** verilog/pciagg_pkg.sv ***
// package: register map, field positions and carriers of the interrupt aggregator
package pciagg_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] PCIAGG_PME_DET_OFS  = 8'h00;
  localparam logic [7:0] PCIAGG_PME_EN_OFS   = 8'h04;
  localparam logic [7:0] PCIAGG_ERR_DET_OFS  = 8'h08;
  localparam logic [7:0] PCIAGG_ERR_EN_OFS   = 8'h0C;
  localparam logic [7:0] PCIAGG_RT_STS_OFS   = 8'h10;
  localparam logic [7:0] PCIAGG_RT_CTL_OFS   = 8'h14;
  localparam logic [7:0] PCIAGG_RE_STS_OFS   = 8'h18;
  localparam logic [7:0] PCIAGG_RE_CMD_OFS   = 8'h1C;
  localparam logic [7:0] PCIAGG_COR_STS_OFS  = 8'h20;
  localparam logic [7:0] PCIAGG_COR_MSK_OFS  = 8'h24;
  localparam logic [7:0] PCIAGG_UNC_STS_OFS  = 8'h28;
  localparam logic [7:0] PCIAGG_UNC_MSK_OFS  = 8'h2C;
  localparam logic [7:0] PCIAGG_UNC_SEV_OFS  = 8'h30;
  localparam logic [7:0] PCIAGG_DEV_CTL_OFS  = 8'h34;
  localparam logic [7:0] PCIAGG_CMD_OFS      = 8'h38;
  localparam logic [7:0] PCIAGG_SEC_STS_OFS  = 8'h3C;
  localparam logic [7:0] PCIAGG_SEC_MSK_OFS  = 8'h40;
  localparam logic [7:0] PCIAGG_SLOT_CTL_OFS = 8'h44;
  localparam logic [7:0] PCIAGG_SLOT_STS_OFS = 8'h48;
  localparam logic [7:0] PCIAGG_PM_CTL_OFS   = 8'h4C;
  localparam logic [7:0] PCIAGG_CPL_TMO_OFS  = 8'h50;
  localparam logic [7:0] PCIAGG_SRC_OFS      = 8'h54;
  localparam logic [7:0] PCIAGG_SRC_MSK_OFS  = 8'h58;

  // ****************************************
  // reset values and field positions
  // ****************************************
  localparam logic [31:0] PCIAGG_COR_MSK_RST = 32'h0000_2000;
  localparam logic [31:0] PCIAGG_CPL_TMO_RST = 32'h0000_FFFF;
  localparam int PCIAGG_CTF_BIT       = 0;
  localparam int PCIAGG_RT_PME_STS    = 16;
  localparam int PCIAGG_RT_PME_IE     = 3;
  localparam int PCIAGG_RE_FATAL      = 6;
  localparam int PCIAGG_RE_NONFATAL   = 5;
  localparam int PCIAGG_RE_COR        = 0;
  localparam int PCIAGG_EN_FATAL      = 2;
  localparam int PCIAGG_EN_NONFATAL   = 1;
  localparam int PCIAGG_EN_COR        = 0;
  localparam int PCIAGG_CMD_SERR      = 8;
  localparam int PCIAGG_CMD_PERR      = 6;
  localparam int PCIAGG_SEC_MDPE      = 8;
  localparam int PCIAGG_SEC_LO        = 11;
  localparam int PCIAGG_SEC_HI        = 15;
  localparam int PCIAGG_SLOT_CC       = 4;
  localparam int PCIAGG_SLOT_HPIE     = 5;
  localparam int PCIAGG_PM_PMEE       = 8;
  localparam int PCIAGG_NSRC          = 11;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pciagg_req_t;

  typedef struct packed {
    logic [31:0] pme_msg;
    logic [31:0] err;
    logic [31:0] rt_sts;
    logic [31:0] re_sts;
    logic [31:0] cor_sts;
    logic [31:0] unc_sts;
    logic [31:0] sec_sts;
    logic [31:0] slot_sts;
  } pciagg_evt_t;

endpackage

// *** verilog/pciagg_top.sv ***
// module: internal interrupt aggregator of the express controller
`timescale 1ns/1ps
// Notes on behaviour
// - pme/message detect and enable raise interrupt
// - controller error detect and enable raise interrupt
// - root pme status with pme interrupt enable
// - fatal messages with either fatal enable
// - non-fatal messages with either non-fatal enable
// - correctable messages with either correctable enable
// - unmasked correctable error while reporting enabled
// - unmasked fatal uncorrectable with fatal or serr
// - unmasked non-fatal uncorrectable with non-fatal or serr
// - master data parity unmasked with parity response
// - secondary bits 11..15 while mask clear
// - slot bits 0..3 need enables and power state 0 or pme enable
// - command completed needs two enables only
// - completion timeout sets error detect bit 0, which interrupts when error enable bit 0 is set
module pciagg_top
  import pciagg_pkg::*;
#(
  parameter logic [31:0] CPL_TMO_DEFAULT = PCIAGG_CPL_TMO_RST
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire pciagg_req_t i_req,
  input  wire pciagg_evt_t i_evt,
  input  wire logic        i_np_issue,
  input  wire logic        i_cpl_recv,
  output logic [31:0]      o_rdata,
  output logic             o_irq
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [31:0]            pme_det;
    logic [31:0]            pme_en;
    logic [31:0]            err_det;
    logic [31:0]            err_en;
    logic [31:0]            rt_sts;
    logic [31:0]            rt_ctl;
    logic [31:0]            re_sts;
    logic [31:0]            re_cmd;
    logic [31:0]            cor_sts;
    logic [31:0]            cor_msk;
    logic [31:0]            unc_sts;
    logic [31:0]            unc_msk;
    logic [31:0]            unc_sev;
    logic [31:0]            dev_ctl;
    logic [31:0]            cmd;
    logic [31:0]            sec_sts;
    logic [31:0]            sec_msk;
    logic [31:0]            slot_ctl;
    logic [31:0]            slot_sts;
    logic [31:0]            pm_ctl;
    logic [31:0]            cpl_tmo;
    logic [PCIAGG_NSRC-1:0] src_msk;
    logic                   np_busy;
    logic [31:0]            np_cnt;
    logic [31:0]            rdata;
    logic                   irq;
  } pciagg_state_t;

  typedef enum {
    SEL_NONE,
    SEL_PME_DET,
    SEL_PME_EN,
    SEL_ERR_DET,
    SEL_ERR_EN,
    SEL_RT_STS,
    SEL_RT_CTL,
    SEL_RE_STS,
    SEL_RE_CMD,
    SEL_COR_STS,
    SEL_COR_MSK,
    SEL_UNC_STS,
    SEL_UNC_MSK,
    SEL_UNC_SEV,
    SEL_DEV_CTL,
    SEL_CMD,
    SEL_SEC_STS,
    SEL_SEC_MSK,
    SEL_SLOT_CTL,
    SEL_SLOT_STS,
    SEL_PM_CTL,
    SEL_CPL_TMO,
    SEL_SRC,
    SEL_SRC_MSK
  } pciagg_sel_t;

  pciagg_state_t          s_q;
  pciagg_state_t          s_d;
  pciagg_sel_t            sel;
  logic [PCIAGG_NSRC-1:0] src;
  logic                   tmo_hit;

  // set wins over a clear arriving in the same cycle
  function automatic logic [31:0] w1c(input logic [31:0] cur,
                                      input logic [31:0] set,
                                      input logic        hit,
                                      input logic [31:0] wdata);
    logic [31:0] clr;
    clr = hit ? wdata : 32'h0000_0000;
    return set | (cur & ~clr);
  endfunction

  // one decoder feeds the write, clear and read paths so their maps cannot drift apart
  function automatic pciagg_sel_t reg_sel(input logic [7:0] a);
    pciagg_sel_t s;
    s = SEL_NONE;
    if (a == PCIAGG_PME_DET_OFS) begin
      s = SEL_PME_DET;
    end else if (a == PCIAGG_PME_EN_OFS) begin
      s = SEL_PME_EN;
    end else if (a == PCIAGG_ERR_DET_OFS) begin
      s = SEL_ERR_DET;
    end else if (a == PCIAGG_ERR_EN_OFS) begin
      s = SEL_ERR_EN;
    end else if (a == PCIAGG_RT_STS_OFS) begin
      s = SEL_RT_STS;
    end else if (a == PCIAGG_RT_CTL_OFS) begin
      s = SEL_RT_CTL;
    end else if (a == PCIAGG_RE_STS_OFS) begin
      s = SEL_RE_STS;
    end else if (a == PCIAGG_RE_CMD_OFS) begin
      s = SEL_RE_CMD;
    end else if (a == PCIAGG_COR_STS_OFS) begin
      s = SEL_COR_STS;
    end else if (a == PCIAGG_COR_MSK_OFS) begin
      s = SEL_COR_MSK;
    end else if (a == PCIAGG_UNC_STS_OFS) begin
      s = SEL_UNC_STS;
    end else if (a == PCIAGG_UNC_MSK_OFS) begin
      s = SEL_UNC_MSK;
    end else if (a == PCIAGG_UNC_SEV_OFS) begin
      s = SEL_UNC_SEV;
    end else if (a == PCIAGG_DEV_CTL_OFS) begin
      s = SEL_DEV_CTL;
    end else if (a == PCIAGG_CMD_OFS) begin
      s = SEL_CMD;
    end else if (a == PCIAGG_SEC_STS_OFS) begin
      s = SEL_SEC_STS;
    end else if (a == PCIAGG_SEC_MSK_OFS) begin
      s = SEL_SEC_MSK;
    end else if (a == PCIAGG_SLOT_CTL_OFS) begin
      s = SEL_SLOT_CTL;
    end else if (a == PCIAGG_SLOT_STS_OFS) begin
      s = SEL_SLOT_STS;
    end else if (a == PCIAGG_PM_CTL_OFS) begin
      s = SEL_PM_CTL;
    end else if (a == PCIAGG_CPL_TMO_OFS) begin
      s = SEL_CPL_TMO;
    end else if (a == PCIAGG_SRC_OFS) begin
      s = SEL_SRC;
    end else if (a == PCIAGG_SRC_MSK_OFS) begin
      s = SEL_SRC_MSK;
    end
    return s;
  endfunction

  function automatic logic wr_hit(input pciagg_req_t r, input pciagg_sel_t s);
    return r.wr && (reg_sel(r.addr) == s);
  endfunction

  assign sel = reg_sel(i_req.addr);

  // ****************************************
  // qualified sources
  // ****************************************
  always_comb begin
    src = '0;
    src[0] = |(s_q.pme_det & s_q.pme_en);
    src[1] = |(s_q.err_det & s_q.err_en);
    src[2] = s_q.rt_sts[PCIAGG_RT_PME_STS] & s_q.rt_ctl[PCIAGG_RT_PME_IE];
    src[3] = s_q.re_sts[PCIAGG_RE_FATAL]
           & (s_q.re_cmd[PCIAGG_EN_FATAL] | s_q.rt_ctl[PCIAGG_EN_FATAL]);
    src[4] = s_q.re_sts[PCIAGG_RE_NONFATAL]
           & (s_q.re_cmd[PCIAGG_EN_NONFATAL] | s_q.rt_ctl[PCIAGG_EN_NONFATAL]);
    src[5] = s_q.re_sts[PCIAGG_RE_COR]
           & (s_q.re_cmd[PCIAGG_EN_COR] | s_q.rt_ctl[PCIAGG_EN_COR]);
    src[6] = (|(s_q.cor_sts & ~s_q.cor_msk)) & s_q.re_cmd[PCIAGG_EN_COR];
    src[7] = (|(s_q.unc_sts & ~s_q.unc_msk & s_q.unc_sev))
           & (s_q.dev_ctl[PCIAGG_EN_FATAL] | s_q.cmd[PCIAGG_CMD_SERR]);
    src[8] = (|(s_q.unc_sts & ~s_q.unc_msk & ~s_q.unc_sev))
           & (s_q.dev_ctl[PCIAGG_EN_NONFATAL] | s_q.cmd[PCIAGG_CMD_SERR]);
    src[9] = (s_q.sec_sts[PCIAGG_SEC_MDPE] & ~s_q.sec_msk[0] & s_q.cmd[PCIAGG_CMD_PERR])
           | (|(s_q.sec_sts[PCIAGG_SEC_HI:PCIAGG_SEC_LO] & ~s_q.sec_msk[5:1]));
    src[10] = ((|(s_q.slot_sts[3:0] & s_q.slot_ctl[3:0])) & s_q.slot_ctl[PCIAGG_SLOT_HPIE]
              & ((s_q.pm_ctl[1:0] == 2'h0) | s_q.pm_ctl[PCIAGG_PM_PMEE]))
            | (s_q.slot_sts[PCIAGG_SLOT_CC] & s_q.slot_ctl[PCIAGG_SLOT_CC]
              & s_q.slot_ctl[PCIAGG_SLOT_HPIE]);
  end

  // ****************************************
  // completion timer
  // ****************************************
  // one outstanding request tracked; a new issue restarts the count
  assign tmo_hit = s_q.np_busy && !i_cpl_recv && !i_np_issue
                && (s_q.np_cnt >= s_q.cpl_tmo);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [31:0] ctf;
    s_d = s_q;
    ctf = 32'h0000_0000;
    ctf[PCIAGG_CTF_BIT] = tmo_hit;

    // timer
    if (i_np_issue) begin
      s_d.np_busy = 1'b1;
      s_d.np_cnt  = 32'h0000_0000;
    end else if (i_cpl_recv || tmo_hit) begin
      s_d.np_busy = 1'b0;
      s_d.np_cnt  = 32'h0000_0000;
    end else if (s_q.np_busy) begin
      s_d.np_cnt = s_q.np_cnt + 32'h0000_0001;
    end

    // sticky status, write one to clear
    s_d.pme_det  = w1c(s_q.pme_det,
                       i_evt.pme_msg,
                       wr_hit(i_req, SEL_PME_DET),
                       i_req.wdata);
    s_d.err_det  = w1c(s_q.err_det,
                       i_evt.err | ctf,
                       wr_hit(i_req, SEL_ERR_DET),
                       i_req.wdata);
    s_d.rt_sts   = w1c(s_q.rt_sts,
                       i_evt.rt_sts,
                       wr_hit(i_req, SEL_RT_STS),
                       i_req.wdata);
    s_d.re_sts   = w1c(s_q.re_sts,
                       i_evt.re_sts,
                       wr_hit(i_req, SEL_RE_STS),
                       i_req.wdata);
    s_d.cor_sts  = w1c(s_q.cor_sts,
                       i_evt.cor_sts,
                       wr_hit(i_req, SEL_COR_STS),
                       i_req.wdata);
    s_d.unc_sts  = w1c(s_q.unc_sts,
                       i_evt.unc_sts,
                       wr_hit(i_req, SEL_UNC_STS),
                       i_req.wdata);
    s_d.sec_sts  = w1c(s_q.sec_sts,
                       i_evt.sec_sts,
                       wr_hit(i_req, SEL_SEC_STS),
                       i_req.wdata);
    s_d.slot_sts = w1c(s_q.slot_sts,
                       i_evt.slot_sts,
                       wr_hit(i_req, SEL_SLOT_STS),
                       i_req.wdata);

    // plain control registers
    if (i_req.wr) begin
      if (sel == SEL_PME_EN) begin
        s_d.pme_en = i_req.wdata;
      end else if (sel == SEL_ERR_EN) begin
        s_d.err_en = i_req.wdata;
      end else if (sel == SEL_RT_CTL) begin
        s_d.rt_ctl = i_req.wdata;
      end else if (sel == SEL_RE_CMD) begin
        s_d.re_cmd = i_req.wdata;
      end else if (sel == SEL_COR_MSK) begin
        s_d.cor_msk = i_req.wdata;
      end else if (sel == SEL_UNC_MSK) begin
        s_d.unc_msk = i_req.wdata;
      end else if (sel == SEL_UNC_SEV) begin
        s_d.unc_sev = i_req.wdata;
      end else if (sel == SEL_DEV_CTL) begin
        s_d.dev_ctl = i_req.wdata;
      end else if (sel == SEL_CMD) begin
        s_d.cmd = i_req.wdata;
      end else if (sel == SEL_SEC_MSK) begin
        s_d.sec_msk = i_req.wdata;
      end else if (sel == SEL_SLOT_CTL) begin
        s_d.slot_ctl = i_req.wdata;
      end else if (sel == SEL_PM_CTL) begin
        s_d.pm_ctl = i_req.wdata;
      end else if (sel == SEL_CPL_TMO) begin
        s_d.cpl_tmo = i_req.wdata;
      end else if (sel == SEL_SRC_MSK) begin
        s_d.src_msk = i_req.wdata[PCIAGG_NSRC-1:0];
      end
    end

    // read data, valid only in the cycle after the strobe
    s_d.rdata = 32'h0000_0000;
    if (i_req.rd) begin
      if (sel == SEL_PME_DET) begin
        s_d.rdata = s_q.pme_det;
      end else if (sel == SEL_PME_EN) begin
        s_d.rdata = s_q.pme_en;
      end else if (sel == SEL_ERR_DET) begin
        s_d.rdata = s_q.err_det;
      end else if (sel == SEL_ERR_EN) begin
        s_d.rdata = s_q.err_en;
      end else if (sel == SEL_RT_STS) begin
        s_d.rdata = s_q.rt_sts;
      end else if (sel == SEL_RT_CTL) begin
        s_d.rdata = s_q.rt_ctl;
      end else if (sel == SEL_RE_STS) begin
        s_d.rdata = s_q.re_sts;
      end else if (sel == SEL_RE_CMD) begin
        s_d.rdata = s_q.re_cmd;
      end else if (sel == SEL_COR_STS) begin
        s_d.rdata = s_q.cor_sts;
      end else if (sel == SEL_COR_MSK) begin
        s_d.rdata = s_q.cor_msk;
      end else if (sel == SEL_UNC_STS) begin
        s_d.rdata = s_q.unc_sts;
      end else if (sel == SEL_UNC_MSK) begin
        s_d.rdata = s_q.unc_msk;
      end else if (sel == SEL_UNC_SEV) begin
        s_d.rdata = s_q.unc_sev;
      end else if (sel == SEL_DEV_CTL) begin
        s_d.rdata = s_q.dev_ctl;
      end else if (sel == SEL_CMD) begin
        s_d.rdata = s_q.cmd;
      end else if (sel == SEL_SEC_STS) begin
        s_d.rdata = s_q.sec_sts;
      end else if (sel == SEL_SEC_MSK) begin
        s_d.rdata = s_q.sec_msk;
      end else if (sel == SEL_SLOT_CTL) begin
        s_d.rdata = s_q.slot_ctl;
      end else if (sel == SEL_SLOT_STS) begin
        s_d.rdata = s_q.slot_sts;
      end else if (sel == SEL_PM_CTL) begin
        s_d.rdata = s_q.pm_ctl;
      end else if (sel == SEL_CPL_TMO) begin
        s_d.rdata = s_q.cpl_tmo;
      end else if (sel == SEL_SRC) begin
        s_d.rdata = {{(32-PCIAGG_NSRC){1'h0}}, src};
      end else if (sel == SEL_SRC_MSK) begin
        s_d.rdata = {{(32-PCIAGG_NSRC){1'h0}}, s_q.src_msk};
      end
    end

    // level output; one cycle behind the status so it stays registered
    s_d.irq = |(src & ~s_q.src_msk);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q         <= '0;
      s_q.cor_msk <= PCIAGG_COR_MSK_RST;
      s_q.cpl_tmo <= CPL_TMO_DEFAULT;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_irq   = s_q.irq;

endmodule

// *** tb/pciagg_properties.sv ***
// checker: port-level properties of the interrupt aggregator
`timescale 1ns/1ps
module pciagg_checker
  import pciagg_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire pciagg_req_t i_req,
  input wire pciagg_evt_t i_evt,
  input wire logic        i_np_issue,
  input wire logic        i_cpl_recv,
  input wire logic [31:0] o_rdata,
  input wire logic        o_irq
);
  // ********
  // shadow of the enables the checks rely on
  // ********
  logic [31:0] pme_en_q, err_en_q, rt_ctl_q, sec_msk_q, src_msk_q;
  logic        pend_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {pme_en_q, err_en_q, rt_ctl_q, sec_msk_q, src_msk_q} <= '0;
      pend_q <= 1'b0;
    end else begin
      // stays set after expiry: only widens the rise check
      pend_q <= i_np_issue | (pend_q & ~i_cpl_recv);
      if (i_req.wr) begin
        case (i_req.addr)
          PCIAGG_PME_EN_OFS:  pme_en_q <= i_req.wdata;
          PCIAGG_ERR_EN_OFS:  err_en_q <= i_req.wdata;
          PCIAGG_RT_CTL_OFS:  rt_ctl_q <= i_req.wdata;
          PCIAGG_SEC_MSK_OFS: sec_msk_q <= i_req.wdata;
          PCIAGG_SRC_MSK_OFS: src_msk_q <= i_req.wdata;
          default: ;
        endcase
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ********
  // properties
  // ********
  property p_rd_idle;
    !$past(i_req.rd) |-> o_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_rd_unmapped;
    $past(i_req.rd) && $past(i_req.addr) > PCIAGG_SRC_MSK_OFS |-> o_rdata == 32'h0000_0000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_irq_rise;
    $rose(o_irq) |-> $past(i_evt, 2) != '0 || $past(i_req.wr, 2) || $past(pend_q, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_fall;
    $fell(o_irq) |-> $past(i_req.wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
  property p_pme;
    (i_evt.pme_msg & pme_en_q) != '0 && !i_req.wr && !src_msk_q[0] |-> ##2 o_irq;
  endproperty
  a_pme: assert property (p_pme) else $error("pme source missed");
  property p_err;
    (i_evt.err & err_en_q) != '0 && !i_req.wr && !src_msk_q[1] |-> ##2 o_irq;
  endproperty
  a_err: assert property (p_err) else $error("error source missed");
  property p_root_pme;
    i_evt.rt_sts[16] && rt_ctl_q[3] && !i_req.wr && !src_msk_q[2] |-> ##2 o_irq;
  endproperty
  a_root_pme: assert property (p_root_pme) else $error("root pme missed");
  property p_sec;
    (i_evt.sec_sts[15:11] & ~sec_msk_q[5:1]) != '0 && !i_req.wr && !src_msk_q[9] |-> ##2 o_irq;
  endproperty
  a_sec: assert property (p_sec) else $error("secondary source missed");
endmodule
bind pciagg_top pciagg_checker u_checker (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(i_req), .i_evt(i_evt),
  .i_np_issue(i_np_issue), .i_cpl_recv(i_cpl_recv), .o_rdata(o_rdata), .o_irq(o_irq));

// *** tb/pciagg_intc_model.sv ***
// model of the central interrupt unit fed by the level request
`timescale 1ns/1ps
module pciagg_intc_model (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_irq,
  output int        o_taken
);
  logic irq_q;
  // level input: one request per rising level, held ones are not recounted
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_q   <= 1'b0;
      o_taken <= 0;
    end else begin
      irq_q <= i_irq;
      if (i_irq && !irq_q) begin
        o_taken <= o_taken + 1;
      end
    end
  end
endmodule

// *** tb/pciagg_top_test.sv ***
// self-checking bench of the interrupt aggregator
`timescale 1ns/1ps
module pciagg_top_test
  import pciagg_pkg::*;
;
  localparam logic [31:0] TMO = 32'h0000_0004;
  localparam logic [7:0]  STS [8] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h3C, 8'h48};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  pciagg_req_t req = '0;
  pciagg_evt_t evt = '0;
  logic        np = 1'b0;
  logic        cpl = 1'b0;
  logic [31:0] rdata;
  logic        irq;
  int          taken;
  int          mismatches = 0;
  int          n_checks = 0;
  int          n_exp = 0;
  always #5 clk = ~clk;
  pciagg_top #(.CPL_TMO_DEFAULT(TMO)) DUT (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_evt(evt),
    .i_np_issue(np), .i_cpl_recv(cpl), .o_rdata(rdata), .o_irq(irq));
  pciagg_intc_model u_intc (.i_clk(clk), .i_rst_n(rst_n), .i_irq(irq), .o_taken(taken));
  // ********
  // bus and compare helpers
  // ********
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 cmp(rdata, exp, what);
  endtask
  // pulse one event bit, judge the request, then clear it by write-one
  task automatic fire(input int f, input int b, input logic x);
    pciagg_evt_t e;
    e = '0;
    e[(7 - f) * 32 + b] = 1'b1;
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
    @(posedge clk);
    #1 cmp({31'h0, irq}, {31'h0, x}, "irq raised");
    n_exp += x;
    wr(STS[f], 32'h1 << b);
    @(posedge clk);
    #1 cmp({31'h0, irq}, 32'h0, "irq cleared");
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_regs();
    rd(8'h24, PCIAGG_COR_MSK_RST, "corr mask reset");
    rd(8'h50, TMO, "timeout reset");
    wr(8'h54, 32'hFFFF_FFFF);
    rd(8'h54, 32'h0, "summary");
    wr(8'h5C, 32'hFFFF_FFFF);
    rd(8'h5C, 32'h0, "unmapped");
  endtask
  task automatic t_err();
    int n;
    wr(8'h0C, 32'h3);
    fire(1, 1, 1'b1);
    @(posedge clk);
    np <= 1'b1;
    @(posedge clk);
    np <= 1'b0;
    cpl <= 1'b1;
    @(posedge clk);
    cpl <= 1'b0;
    repeat (12) @(posedge clk);
    #1 cmp({31'h0, irq}, 32'h0, "cancelled");
    @(posedge clk);
    np <= 1'b1;
    @(posedge clk);
    np <= 1'b0;
    #1;
    for (n = 0; n < 20 && irq !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 20) begin
      mismatches++;
      $display("wrong value at %0t: no timeout irq", $time);
      end_of_test();
    end
    cmp(32'(n), TMO + 2, "timeout cycles");
    n_exp++;
    rd(8'h08, 32'h1, "timeout flag");
    wr(8'h08, 32'h1);
    @(posedge clk);
    #1 cmp({31'h0, irq}, 32'h0, "flag cleared");
  endtask
  task automatic t_root();
    int sb [3] = '{6, 5, 0};
    wr(8'h14, 32'h8);
    fire(2, 16, 1'b1);
    wr(8'h14, 32'h0);
    fire(2, 16, 1'b0);
    for (int k = 0; k < 3; k++) begin
      wr(8'h1C, 32'h1 << (2 - k));
      fire(3, sb[k], 1'b1);
      wr(8'h1C, 32'h0);
      wr(8'h14, 32'h1 << (2 - k));
      fire(3, sb[k], 1'b1);
      wr(8'h14, 32'h0);
      fire(3, sb[k], 1'b0);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    wr(8'h04, 32'h8);
    fire(0, 3, 1'b1);
    fire(0, 2, 1'b0);
    t_err();
    t_root();
    wr(8'h1C, 32'h1);
    fire(4, 13, 1'b0);
    fire(4, 0, 1'b1);
    wr(8'h1C, 32'h0);
    fire(4, 0, 1'b0);
    wr(8'h30, 32'h10);
    wr(8'h34, 32'h4);
    fire(5, 4, 1'b1);
    fire(5, 5, 1'b0);
    wr(8'h34, 32'h2);
    fire(5, 4, 1'b0);
    fire(5, 5, 1'b1);
    wr(8'h34, 32'h0);
    wr(8'h38, 32'h100);
    fire(5, 4, 1'b1);
    fire(5, 5, 1'b1);
    wr(8'h2C, 32'h30);
    fire(5, 4, 1'b0);
    wr(8'h38, 32'h40);
    fire(6, 8, 1'b1);
    wr(8'h40, 32'h1);
    fire(6, 8, 1'b0);
    wr(8'h38, 32'h0);
    for (int b = 11; b <= 15; b++) begin
      wr(8'h40, 32'h1 << (b - 10));
      fire(6, b, 1'b0);
      wr(8'h40, 32'h0);
      fire(6, b, 1'b1);
    end
    wr(8'h44, 32'h2F);
    for (int b = 0; b < 4; b++) begin
      fire(7, b, 1'b1);
    end
    wr(8'h4C, 32'h3);
    fire(7, 0, 1'b0);
    wr(8'h4C, 32'h103);
    fire(7, 1, 1'b1);
    wr(8'h44, 32'h1F);
    wr(8'h4C, 32'h3);
    fire(7, 4, 1'b0);
    wr(8'h44, 32'h30);
    fire(7, 4, 1'b1);
    wr(8'h58, 32'h400);
    fire(7, 4, 1'b0);
    cmp(32'(taken), 32'(n_exp), "irq count");
    end_of_test();
  end
endmodule
